//--- rtl/plt_pkg.sv
// Function
// R1: 100 Mb/s: first J bit leaves on the line 11 bit times after TX_EN sampled.
// R2: 100 Mb/s: first T bit leaves on the line 15 bit times after TX_EN drops.
// R3: transmit dibits reach the line after 11 (100 Mb/s) or 5 (10 Mb/s) bits.
// R4: 10 Mb/s: line drive starts 5 bit times after TX_EN asserts.
// R5: 100 Mb/s: CRS_DV rises 6 bit times after J arrives on the line.
// R6: 100 Mb/s: CRS_DV falls 16 bit times after T arrives on the line.
// R7: receive dibits reach RXD after 15 (100 Mb/s) or 11 (10 Mb/s) bits.
// R8: 10 Mb/s: CRS_DV rises 12 bit times after preamble arrives.
// R9: 10 Mb/s: CRS_DV falls 8 bit times after the idle pattern starts.
// R10: 10 Mb/s: continuous TX_EN for 70 ms raises jabber.
// R11: 10 Mb/s: jabber clears 70 ms after TX_EN returns low.
// R12: management read bits launch after MDC rising edge; station samples later.
// R13: RMII: receive data and CRS_DV launch from reference clock rising edge.
// R14: RMII: MAC drives transmit data and TX_EN on the reference clock.
// R15: SMII: serial receive data launches from reference clock rising edge.
// R16: SMII: MAC drives transmit data and sync on the reference clock.
// R17: SS-SMII: receive data and sync launch from forwarded receive clock rise.
// R18: SS-SMII: MAC drives transmit data and sync on the transmit clock; the port takes transmit data on REF_CLK_I in every mode.
// R19: station keeps MDC within rate and changes MDIO away from MDC rise.
// R20: every latency is fixed per mode and speed, counted in bit ticks; the jabber interval is counted in reference clock cycles.
`default_nettype none
package plt_pkg;
  localparam int HIST_D = 17;
  localparam int TX_J_LAT_100 = 11;
  localparam int TX_T_LAT_100 = 15;
  localparam int TX_LAT_10 = 5;
  localparam int CRS_ON_100 = 6;
  localparam int CRS_OFF_100 = 16;
  localparam int RX_LAT_100 = 15;
  localparam int CRS_ON_10 = 12;
  localparam int CRS_OFF_10 = 8;
  localparam int RX_LAT_10 = 11;
  localparam int CLK_KHZ = 40000;
  localparam int JAB_TIME_MS = 70;
  localparam int JAB_CYC_DEF = JAB_TIME_MS * CLK_KHZ;
  localparam int JAB_W = 22;
  localparam int FIFO_W = 3;
  localparam int FIFO_D = 16;
  localparam int MD_HDR_BITS = 12;
  localparam int MD_TA_BITS = 2;
  localparam int MD_DATA_BITS = 16;
  localparam logic [1:0] MD_OP_READ = 2'h2;
  localparam logic [3:0] MD_START_PAT = 4'hD;
  localparam int ST_LINE_EN_BIT = 0;
  localparam int ST_CRS_BIT = 1;
  localparam int ST_SPEED_BIT = 2;
  localparam int ST_JABBER_BIT = 3;

  typedef enum logic [1:0] {
    MODE_RMII = 2'b00,
    MODE_SMII = 2'b01,
    MODE_SSSMII = 2'b10
  } plt_mode_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_HDR = 3'b001,
    MS_TA = 3'b010,
    MS_DATA = 3'b011,
    MS_SKIP = 3'b100
  } plt_mstate_t;

  typedef struct packed {
    logic en;
    logic [1:0] d;
  } plt_dibit_t;

  typedef struct packed {
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3;
    plt_dibit_t rxp_s1;
    plt_dibit_t rxp_s2;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    plt_dibit_t [HIST_D-1:0] txh;
    plt_dibit_t [HIST_D-1:0] rxh;
    logic [1:0] tx_pair;
    logic tx_en;
    logic tx_j;
    logic tx_t;
    logic [1:0] rx_pend;
    logic crs_pend;
    logic crs_dv;
    logic [1:0] rxd;
    logic rx_sync;
    logic rx_clk;
    logic jabber;
    logic [JAB_W-1:0] jab_cnt;
    plt_mstate_t mst;
    logic [4:0] mcnt;
    logic [13:0] msr;
    logic [15:0] mword;
    logic mdio_o;
    logic mdio_oe;
  } plt_state_t;
endpackage
`default_nettype wire

//--- rtl/plt_port.sv
`default_nettype none
// transmit queue between the MAC and the bit-tick driven line pipeline
module plt_fifo #(
  parameter int W = 3,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } plt_fifo_st_t;
  plt_fifo_st_t s, next_s;
  logic push, pop;

  always_comb begin
    next_s = s;
    push = in_valid_i & s.rdy;
    pop = out_ready_i & s.vld;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_s.rdy = next_s.cnt < (AW+1)'(D);
    next_s.vld = next_s.cnt != '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.rdy <= 1'b1;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign in_ready_o = s.rdy;
  assign out_valid_o = s.vld;
  assign out_data_o = s.mem[s.rp];
endmodule

module plt_port #(
  parameter int JAB_CYC = plt_pkg::JAB_CYC_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic SPEED100_I,
  input wire plt_pkg::plt_mode_t MODE_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  input wire plt_pkg::plt_dibit_t TX_WORD_I,
  input wire logic LINE_CLK_I,
  input wire logic [1:0] LINE_RX_PAIR_I,
  input wire logic LINE_RX_CS_I,
  output logic [1:0] LINE_TX_PAIR_O,
  output logic LINE_TX_EN_O,
  output logic LINE_TX_J_O,
  output logic LINE_TX_T_O,
  output logic CRS_DV_O,
  output logic [1:0] RXD_O,
  output logic RX_SYNC_O,
  output logic RX_CLK_O,
  output logic JABBER_O,
  input wire logic MDC_I,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_O
);
  import plt_pkg::*;

  plt_state_t s, next_s;
  plt_dibit_t pop_word;
  logic pop_valid;
  logic tick, mdc_rise, load_rx;
  int unsigned tx_tap, rx_tap, on_tap, off_tap;

  // tx queue drains one word per bit tick; the MAC may stall on TX_READY_O
  plt_fifo #(.W(FIFO_W), .D(FIFO_D)) u_txq (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .in_valid_i(TX_VALID_I),
    .in_ready_o(TX_READY_O),
    .in_data_i(TX_WORD_I),
    .out_valid_o(pop_valid),
    .out_ready_i(tick),
    .out_data_o(pop_word)
  );

  assign tick = s.lclk_s2 & ~s.lclk_s3;
  assign mdc_rise = s.mdc_s2 & ~s.mdc_s3;
  assign tx_tap = SPEED100_I ? TX_J_LAT_100 : TX_LAT_10; // see R20
  assign rx_tap = SPEED100_I ? RX_LAT_100 : RX_LAT_10;
  assign on_tap = SPEED100_I ? CRS_ON_100 : CRS_ON_10;
  assign off_tap = SPEED100_I ? CRS_OFF_100 : CRS_OFF_10;
  // rx outputs move only where the forwarded clock rises in SS-SMII
  assign load_rx = (MODE_I != MODE_SSSMII) | ~s.rx_clk;

  always_comb begin
    next_s = s;
    // pin inputs pass two flops before use
    next_s.lclk_s1 = LINE_CLK_I;
    next_s.lclk_s2 = s.lclk_s1;
    next_s.lclk_s3 = s.lclk_s2;
    next_s.rxp_s1 = {LINE_RX_CS_I, LINE_RX_PAIR_I};
    next_s.rxp_s2 = s.rxp_s1;
    next_s.mdc_s1 = MDC_I;
    next_s.mdc_s2 = s.mdc_s1;
    next_s.mdc_s3 = s.mdc_s2;
    next_s.mdio_s1 = MDIO_I;
    next_s.mdio_s2 = s.mdio_s1;
    next_s.tx_j = 1'b0;
    next_s.tx_t = 1'b0;

    if (tick) begin
      // transmit: fixed tap per speed from the sampled word
      next_s.txh = {s.txh[HIST_D-2:0], pop_valid ? pop_word : '0}; // see R14
      next_s.tx_pair = s.txh[tx_tap-1].d; // see R3
      if (SPEED100_I) begin
        next_s.tx_j = s.txh[TX_J_LAT_100-1].en
                      & ~s.txh[TX_J_LAT_100].en; // see R1
        next_s.tx_t = ~s.txh[TX_T_LAT_100-1].en
                      & s.txh[TX_T_LAT_100].en; // see R2
        next_s.tx_en = s.txh[TX_J_LAT_100-1].en
                       | s.txh[TX_T_LAT_100-1].en;
      end else begin
        next_s.tx_en = s.txh[TX_LAT_10-1].en & ~s.jabber; // see R4
      end
      // receive: carrier taps set and clear CRS_DV, data tap feeds RXD
      next_s.rxh = {s.rxh[HIST_D-2:0], s.rxp_s2};
      if (s.rxh[on_tap-1].en & ~s.rxh[on_tap].en) begin
        next_s.crs_pend = 1'b1; // see R5, R8
      end else if (~s.rxh[off_tap-1].en & s.rxh[off_tap].en) begin
        next_s.crs_pend = 1'b0; // see R6, R9
      end
      next_s.rx_pend = s.rxh[rx_tap-1].d; // see R7
    end

    next_s.rx_clk = (MODE_I == MODE_SSSMII) ? ~s.rx_clk : 1'b0;
    if (load_rx) begin
      next_s.crs_dv = s.crs_pend; // see R13
      next_s.rxd = s.crs_pend ? s.rx_pend : 2'h0; // see R15, R17
      next_s.rx_sync = s.crs_pend & ~s.crs_dv;
    end

    // jabber counts reference cycles of the MAC-side enable
    if (SPEED100_I) begin
      next_s.jabber = 1'b0;
      next_s.jab_cnt = '0;
    end else if (s.txh[0].en != s.jabber) begin
      if (s.jab_cnt == JAB_W'(JAB_CYC - 1)) begin
        next_s.jabber = ~s.jabber; // see R10, R11
        next_s.jab_cnt = '0;
      end else begin
        next_s.jab_cnt = s.jab_cnt + 1'b1;
      end
    end else begin
      next_s.jab_cnt = '0;
    end

    // management frame: sample on MDC rise, launch read bits on MDC rise
    if (mdc_rise) begin
      next_s.msr = {s.msr[12:0], s.mdio_s2};
      case (s.mst)
        MS_IDLE: begin
          next_s.mdio_oe = 1'b0;
          if ({s.msr[2:0], s.mdio_s2} == MD_START_PAT) begin
            next_s.mst = MS_HDR;
            next_s.mcnt = '0;
          end
        end
        MS_HDR: begin
          if (s.mcnt == 5'(MD_HDR_BITS - 1)) begin
            next_s.mcnt = '0;
            next_s.mst = (s.msr[10:9] == MD_OP_READ) ? MS_TA : MS_SKIP;
          end else begin
            next_s.mcnt = s.mcnt + 1'b1;
          end
        end
        MS_TA: begin
          next_s.mcnt = s.mcnt + 1'b1;
          if (s.mcnt == 5'(MD_TA_BITS - 1)) begin
            next_s.mdio_o = 1'b0; // see R12
            next_s.mdio_oe = 1'b1;
            next_s.mcnt = '0;
            next_s.mst = MS_DATA;
            next_s.mword = '0;
            next_s.mword[ST_LINE_EN_BIT] = s.tx_en;
            next_s.mword[ST_CRS_BIT] = s.crs_dv;
            next_s.mword[ST_SPEED_BIT] = SPEED100_I;
            next_s.mword[ST_JABBER_BIT] = s.jabber;
          end
        end
        MS_DATA: begin
          if (s.mcnt == 5'(MD_DATA_BITS)) begin
            next_s.mdio_oe = 1'b0;
            next_s.mdio_o = 1'b0;
            next_s.mst = MS_IDLE;
          end else begin
            next_s.mdio_o = s.mword[15]; // see R12
            next_s.mword = {s.mword[14:0], 1'b0};
            next_s.mcnt = s.mcnt + 1'b1;
          end
        end
        MS_SKIP: begin
          next_s.mcnt = s.mcnt + 1'b1;
          if (s.mcnt == 5'(MD_TA_BITS + MD_DATA_BITS - 1)) begin
            next_s.mst = MS_IDLE;
          end
        end
        default: begin
          next_s.mst = MS_IDLE;
          next_s.mdio_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s <= '0;
    end else if (CE_I) begin
      s <= next_s;
    end
  end

  assign LINE_TX_PAIR_O = s.tx_pair;
  assign LINE_TX_EN_O = s.tx_en;
  assign LINE_TX_J_O = s.tx_j;
  assign LINE_TX_T_O = s.tx_t;
  assign CRS_DV_O = s.crs_dv;
  assign RXD_O = s.rxd;
  assign RX_SYNC_O = s.rx_sync;
  assign RX_CLK_O = s.rx_clk;
  assign JABBER_O = s.jabber;
  assign MDIO_O = s.mdio_o;
  assign MDIO_OE_O = s.mdio_oe;

  // helper: ticks since the last rising enable at the transmit queue exit and at the receive history input
  logic [4:0] tx_age;
  logic [4:0] rx_age;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      tx_age <= 5'h1F;
      rx_age <= 5'h1F;
    end else if (CE_I && tick) begin
      if (pop_valid && pop_word.en && !s.txh[0].en) begin
        tx_age <= 5'h00;
      end else if (tx_age != 5'h1F) begin
        tx_age <= tx_age + 5'h01;
      end
      if (s.rxp_s2.en && !s.rxh[0].en) begin
        rx_age <= 5'h00;
      end else if (rx_age != 5'h1F) begin
        rx_age <= rx_age + 5'h01;
      end
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  a_j_start_lat: assert property ( // see R1
    CE_I && $rose(s.tx_j) |-> SPEED100_I && tx_age == 5'(TX_J_LAT_100))
    else $error("J launched at wrong bit count");
  a_t_end_seen: assert property ( // see R2
    CE_I && tick && SPEED100_I && !s.txh[14].en && s.txh[15].en
    |=> LINE_TX_T_O)
    else $error("T not launched after enable drop");
  a_tx_data_tap: assert property ( // see R3
    CE_I && tick && SPEED100_I |=> LINE_TX_PAIR_O == $past(s.txh[10].d))
    else $error("line dibit not from fixed tap");
  a_tx10_drive: assert property ( // see R4
    CE_I && tick && !SPEED100_I && !s.jabber && s.txh[4].en |=> LINE_TX_EN_O)
    else $error("10M line drive missing");
  a_crs_on_100: assert property ( // see R5
    CE_I && $rose(s.crs_pend) && SPEED100_I |-> rx_age == 5'(CRS_ON_100))
    else $error("CRS_DV rise at wrong bit count");
  a_crs_off_tap: assert property ( // see R6, R9
    CE_I && tick && !s.rxh[off_tap-1].en && s.rxh[off_tap].en
    |=> !s.crs_pend)
    else $error("carrier not dropped at off tap");
  a_rxd_tap: assert property ( // see R7
    CE_I && tick |=> s.rx_pend == $past(s.rxh[rx_tap-1].d))
    else $error("receive dibit not from fixed tap");
  a_crs_on_10: assert property ( // see R8
    CE_I && $rose(s.crs_pend) && !SPEED100_I |-> rx_age == 5'(CRS_ON_10))
    else $error("10M CRS_DV rise at wrong bit count");
  a_jab_set: assert property ( // see R10, R11
    CE_I && $changed(JABBER_O) |->
    $past(s.jab_cnt) == JAB_W'(JAB_CYC - 1) && !SPEED100_I)
    else $error("jabber toggled before full interval");
  a_mdio_launch: assert property ( // see R12
    $changed(MDIO_O) || $rose(MDIO_OE_O) |-> $past(mdc_rise))
    else $error("MDIO moved away from MDC rise");
  a_ss_rx_launch: assert property ( // see R17
    MODE_I == MODE_SSSMII && $changed(RXD_O) |-> RX_CLK_O)
    else $error("receive data moved off forwarded clock rise");

  // framing of line pulses, receive outputs and management release
  a_j_pulse_one: assert property ( // see R1
    CE_I && LINE_TX_J_O |=> !LINE_TX_J_O)
    else $error("J pulse longer than one cycle");
  a_jt_speed_only: assert property ( // see R1, R2
    LINE_TX_J_O || LINE_TX_T_O |-> $past(SPEED100_I))
    else $error("J or T pulse outside 100M");
  a_jab_fast_off: assert property ( // see R10
    CE_I && SPEED100_I |=> !JABBER_O)
    else $error("jabber raised at 100M");
  a_jab_blocks_tx: assert property ( // see R10
    CE_I && tick && JABBER_O && !SPEED100_I |=> !LINE_TX_EN_O)
    else $error("line driven during jabber");
  a_rxd_idle_zero: assert property ( // see R7
    !CRS_DV_O |-> RXD_O == 2'h0)
    else $error("receive data moved without carrier");
  a_sync_on_crs: assert property ( // see R13, R15
    CE_I && $rose(RX_SYNC_O) |-> $rose(CRS_DV_O))
    else $error("sync marker without carrier rise");
  a_rxclk_parked: assert property ( // see R17
    CE_I && MODE_I != MODE_SSSMII |=> !RX_CLK_O)
    else $error("receive clock runs outside SS-SMII");
  a_mdio_idle_rel: assert property ( // see R12
    s.mst == MS_IDLE |-> !MDIO_OE_O)
    else $error("MDIO driven while frame idle");
endmodule
`default_nettype wire

//--- verif/plt_mac_model.sv
`default_nettype none
// mac transmit side: offers n words back to back, each held until taken
module plt_mac_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic ready_i,
  output logic valid_o,
  output plt_pkg::plt_dibit_t word_o,
  output logic full_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import plt_pkg::*;
  int sent = 0;
  int total = 0;
  initial begin
    valid_o = 1'b0;
    word_o = '0;
    full_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (valid_o && ready_i) sent++;
      if (valid_o && !ready_i) full_o = 1'b1;
      if (go_i) begin
        sent = 0;
        total = n_i;
        full_o = 1'b0;
      end
      #1;
      valid_o = (sent < total);
      // idle word bus toggles so a stale word is never trusted
      word_o = valid_o ? {1'b1, 2'(sent)} : ~word_o;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_phy_mac_side_latency_timing.sv
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      n_mismatch++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tb_phy_mac_side_latency_timing;
  timeunit 1ns;
  timeprecision 100ps;
  import plt_pkg::*;
  localparam int JAB = 200;
  logic ref_clk = 1'b0;
  logic line_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic spd = 1'b1;
  plt_mode_t mode = MODE_RMII;
  logic mac_go = 1'b0;
  logic [7:0] mac_n = 8'h00;
  logic mac_full, tx_valid, tx_ready;
  plt_dibit_t tx_word;
  logic [1:0] rx_pair = 2'h0;
  logic rx_cs = 1'b0;
  logic [1:0] tx_pair, rxd;
  logic tx_en, tx_j, tx_t, crs, rx_sync, rx_clk, jab, mdio_o, mdio_oe;
  logic mdc = 1'b0;
  logic st_oe = 1'b0;
  logic st_d = 1'b1;
  logic en_d = 1'b0;
  logic crs_d = 1'b0;
  logic jab_d = 1'b0;
  wire mdio_i;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int line_n = 0;
  int j_at, t_at, en_at, con_at, coff_at, sync_at, jon, joff, rxc_n;
  int rise_cyc [4096];
  logic [1:0] txp [4096];
  logic txe [4096];
  logic [1:0] rxs [4096];
  // management line has a pull-up
  assign mdio_i = mdio_oe ? mdio_o : (st_oe ? st_d : 1'b1);

  plt_port #(.JAB_CYC(JAB)) i_dut (
    .REF_CLK_I(ref_clk), .RST_I(rst), .CE_I(ce), .SPEED100_I(spd),
    .MODE_I(mode), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready),
    .TX_WORD_I(tx_word), .LINE_CLK_I(line_clk), .LINE_RX_PAIR_I(rx_pair),
    .LINE_RX_CS_I(rx_cs), .LINE_TX_PAIR_O(tx_pair), .LINE_TX_EN_O(tx_en),
    .LINE_TX_J_O(tx_j), .LINE_TX_T_O(tx_t), .CRS_DV_O(crs), .RXD_O(rxd),
    .RX_SYNC_O(rx_sync), .RX_CLK_O(rx_clk), .JABBER_O(jab), .MDC_I(mdc),
    .MDIO_I(mdio_i), .MDIO_O(mdio_o), .MDIO_OE_O(mdio_oe));
  plt_mac_model i_mac (.clk_i(ref_clk), .go_i(mac_go), .n_i(mac_n),
    .ready_i(tx_ready), .valid_o(tx_valid), .word_o(tx_word),
    .full_o(mac_full));

  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    #37;
    forever #100 line_clk = ~line_clk;
  end
  always @(posedge line_clk) begin
    line_n++;
    rise_cyc[line_n] = cyc;
  end
  always @(negedge line_clk) rx_pair <= 2'(line_n + 1);
  always @(posedge ref_clk) begin
    cyc++;
    txp[line_n] = tx_pair;
    txe[line_n] = tx_en;
    rxs[line_n] = rxd;
    if (tx_j && j_at < 0) j_at = line_n;
    if (tx_t && t_at < 0) t_at = line_n;
    if (tx_en && !en_d && en_at < 0) en_at = line_n;
    if (crs && !crs_d) con_at = line_n;
    if (!crs && crs_d) coff_at = line_n;
    if (rx_sync && sync_at < 0) sync_at = line_n;
    if (jab && !jab_d) jon = cyc;
    if (!jab && jab_d) joff = cyc;
    if (rx_clk) rxc_n++;
    en_d = tx_en;
    crs_d = crs;
    jab_d = jab;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic clr();
    j_at = -1;
    t_at = -1;
    en_at = -1;
    sync_at = -1;
    jon = -1;
    joff = -1;
    rxc_n = 0;
  endtask

  task automatic t_tx(input logic s, input int n);
    int st, lat;
    @(posedge ref_clk);
    #1 spd = s;
    clr();
    lat = s ? 12 : 6;
    @(posedge line_clk);
    repeat (4) @(posedge ref_clk);
    #1 st = line_n;
    mac_n = 8'(n);
    mac_go = 1'b1;
    @(posedge ref_clk);
    #1 mac_go = 1'b0;
    for (int i = 0; i < 4000 && line_n < st + n + 30; i++) @(posedge ref_clk);
    `CHK("tx en", st + lat, en_at)
    for (int i = 0; i < 4; i++) `CHK("tx data", 2'(i), txp[st + lat + i])
    `CHK("j tick", s ? st + 12 : -1, j_at)
    `CHK("t tick", s ? st + n + 16 : -1, t_at)
    `CHK("tx refused", 1'b1, mac_full)
    if (!s && n > 20) begin
      `CHK("jab on", 1'b1, jon - rise_cyc[st + 1] inside {[JAB:JAB + 8]})
      `CHK("jab off", 1'b1, joff - rise_cyc[st + n + 1] inside {[JAB:JAB + 8]})
      `CHK("tx blocked", 1'b0, txe[st + 40])
    end else `CHK("no jab", -1, jon)
    $display("test tx done");
  endtask

  task automatic t_rx(input logic s, input plt_mode_t m);
    int k, e;
    @(posedge ref_clk);
    #1 spd = s;
    mode = m;
    clr();
    @(negedge line_clk);
    k = line_n + 1;
    rx_cs = 1'b1;
    repeat (30) @(negedge line_clk);
    e = line_n + 1;
    rx_cs = 1'b0;
    for (int i = 0; i < 400 && crs; i++) @(posedge ref_clk);
    repeat (16) @(posedge ref_clk);
    `CHK("crs on", k + (s ? 6 : 12), con_at)
    `CHK("crs off", e + (s ? 16 : 8), coff_at)
    `CHK("rx data", 2'(k + 15), rxs[k + 14])
    `CHK("rx sync", con_at, sync_at)
    `CHK("rx clk", m == MODE_SSSMII, rxc_n > 0)
    $display("test rx done");
  endtask

  task automatic mdc_bit(input logic oe, input logic b, output logic [1:0] g);
    st_oe = oe;
    st_d = b;
    repeat (8) @(posedge ref_clk);
    #1 mdc = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 g = {mdio_oe, mdio_i};
    mdc = 1'b0;
  endtask

  task automatic t_mdio(input logic s, input logic [1:0] op,
                        input logic [15:0] ex);
    logic [17:0] hdr;
    logic [1:0] g;
    logic [18:0] oes;
    logic [16:0] dat;
    @(posedge ref_clk);
    #1 spd = s;
    hdr = {6'b111101, op, 10'h000};
    for (int i = 17; i >= 0; i--) mdc_bit(1'b1, hdr[i], g);
    for (int i = 0; i < 19; i++) begin
      mdc_bit(1'b0, 1'b1, g);
      oes = {oes[17:0], g[1]};
      if (i > 0 && i < 18) dat = {dat[15:0], g[0]};
    end
    `CHK("mdio drive", op == 2'h2 ? 19'h3FFFE : 19'h00000, oes)
    if (op == 2'h2) `CHK("mdio data", {1'b0, ex}, dat)
    $display("test mdio done");
  endtask

  task automatic t_ce();
    logic v;
    @(posedge ref_clk);
    #1 ce = 1'b0;
    v = rx_clk;
    repeat (6) @(posedge ref_clk);
    #1 `CHK("ce hold", v, rx_clk)
    ce = 1'b1;
    @(posedge ref_clk);
    #1 `CHK("ce run", ~v, rx_clk)
    $display("test ce done");
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK("reset outs", 6'h20, {tx_ready, crs, jab, mdio_oe, tx_en, rx_clk})
    t_tx(1'b1, 40);
    t_tx(1'b0, 20);
    t_tx(1'b0, 40);
    t_rx(1'b1, MODE_RMII);
    t_rx(1'b0, MODE_SMII);
    t_rx(1'b1, MODE_SSSMII);
    t_ce();
    t_mdio(1'b1, 2'h2, 16'h0004);
    t_mdio(1'b0, 2'h1, 16'h0000);
    t_mdio(1'b0, 2'h2, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
